// ---- eirq_dev.sv ----
// Notes on behaviour
// - User raises request to send one interrupt
// - User holds request until grant appears
// - Grant comes with request when message sent
// - Legacy select: 0 assert, 1 deassert
// - Vector on low bits, count sets width
// - Vector ignored for single-vector MSI
// - Only INTA pin, code 00h
// - Low message data byte shown, informational
// - Multiple message enable shown, 000b..101b
// - Nonzero count gives overridable low bits
// - MSI enable shown; then MSI only if MSI-X is not enabled
// - MSI-X enable shown; then MSI-X only
// - Function mask masks every MSI-X vector
// - Message number field loaded from user
// - User corrects message number when invalidated
`timescale 1ns/10ps

`include "eirq_regs.svh"

module eirq_dev
    import eirq_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // Interrupt request port
    eirq_if.dev              lnk,
    // Host-programmed capability state
    input  wire logic        host_msi_en,
    input  wire logic        host_msix_en,
    input  wire logic        host_msix_fmask,
    input  wire logic [2:0]  host_mm_en,
    input  wire logic [15:0] host_msi_data,
    // Message transmit side
    input  wire logic        tx_ready,
    output logic             tx_valid,
    output eirq_kind_t       tx_kind,
    output logic [15:0]      tx_data,
    // Capability and legacy state
    output logic [4:0]       cap_msgnum,
    output logic             intx_asserted
);

    // ****************************************************************
    // Declarations
    // ****************************************************************

    eirq_state_t state;
    eirq_state_t next_state;
    eirq_kind_t  next_kind;
    logic        grant;
    logic        fmask_block;
    logic [7:0]  vec_mask;
    logic [15:0] next_data;

    // ****************************************************************
    // Mirror of host-programmed enables
    // ****************************************************************

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lnk.mm_enable <= 3'h0;
        end
        else if (host_mm_en > `EIRQ_MM_MAX)
        begin
            lnk.mm_enable <= `EIRQ_MM_MAX;
        end
        else
        begin
            lnk.mm_enable <= host_mm_en;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lnk.msi_on  <= 1'b0;
            lnk.msix_on <= 1'b0;
        end
        else
        begin
            lnk.msi_on  <= host_msi_en;
            lnk.msix_on <= host_msix_en;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lnk.msix_fmask <= 1'b0;
        end
        else
        begin
            lnk.msix_fmask <= host_msix_fmask;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lnk.msi_data_lo <= `EIRQ_RST_BYTE;
        end
        else
        begin
            lnk.msi_data_lo <= host_msi_data[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cap_msgnum <= `EIRQ_RST_MSGNUM;
        end
        else
        begin
            cap_msgnum <= lnk.msg_number;
        end
    end

    // ****************************************************************
    // Message type and payload
    // ****************************************************************

    // MSI-X wins, then MSI, else legacy
    always_comb
    begin
        if (lnk.msix_on)
        begin
            next_kind = EIRQ_KIND_MSIX;
        end
        else if (lnk.msi_on)
        begin
            next_kind = EIRQ_KIND_MSI;
        end
        else
        begin
            next_kind = EIRQ_KIND_INTX;
        end
    end

    assign vec_mask = eirq_vec_mask(lnk.mm_enable);

    always_comb
    begin
        next_data = 16'h0000;
        case (next_kind)
            EIRQ_KIND_MSI:
            begin
                next_data = {host_msi_data[15:8],
                             (host_msi_data[7:0] & ~vec_mask) |
                             (lnk.msi_vector_in & vec_mask)};
            end
            EIRQ_KIND_MSIX:
            begin
                next_data = {8'h00, lnk.msi_vector_in};
            end
            default:
            begin
                next_data = {7'h00, lnk.lvl_deassert, `EIRQ_INTA_CODE};
            end
        endcase
    end

    // ****************************************************************
    // Request and grant
    // ****************************************************************

    assign fmask_block = (next_kind == EIRQ_KIND_MSIX) && lnk.msix_fmask;

    assign grant = lnk.irq_req && (state == EIRQ_IDLE) && tx_ready &&
                   !fmask_block;
    assign lnk.irq_gnt = grant;

    always_comb
    begin
        next_state = state;
        case (state)
            EIRQ_IDLE:
            begin
                if (grant)
                begin
                    next_state = EIRQ_SEND;
                end
            end
            EIRQ_SEND:
            begin
                next_state = EIRQ_IDLE;
            end
            default:
            begin
                next_state = EIRQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= EIRQ_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // Transmit register
    // ****************************************************************

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_valid <= 1'b0;
            tx_kind  <= EIRQ_KIND_INTX;
            tx_data  <= 16'h0000;
        end
        else
        begin
            tx_valid <= grant;
            if (grant)
            begin
                tx_kind <= next_kind;
                tx_data <= next_data;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            intx_asserted <= 1'b0;
        end
        else if (grant && (next_kind == EIRQ_KIND_INTX))
        begin
            intx_asserted <= (lnk.lvl_deassert == `EIRQ_LVL_ASSERT);
        end
    end

endmodule

// ---- eirq_regs.svh ----
`ifndef EIRQ_REGS_SVH
`define EIRQ_REGS_SVH

// Register offsets of the user end (byte addresses)
`define EIRQ_OFS_CTRL      8'h00
`define EIRQ_OFS_VECTOR    8'h04
`define EIRQ_OFS_MSGNUM    8'h08
`define EIRQ_OFS_STATUS    8'h0c
`define EIRQ_OFS_IRQ_STAT  8'h10
`define EIRQ_OFS_IRQ_MASK  8'h14

// CTRL fields
`define EIRQ_CTRL_SEND     0
`define EIRQ_CTRL_DEASSERT 1

// STATUS fields
`define EIRQ_ST_MSI        0
`define EIRQ_ST_MSIX       1
`define EIRQ_ST_FMASK      2
`define EIRQ_ST_MM_LO      3
`define EIRQ_ST_DATA_LO    8
`define EIRQ_ST_BUSY       16

// IRQ_STAT / IRQ_MASK fields
`define EIRQ_EV_DONE       0
`define EIRQ_EV_CFG        1

// Reset values
`define EIRQ_RST_BYTE      8'h00
`define EIRQ_RST_MSGNUM    5'h00
`define EIRQ_RST_EV        2'h0
`define EIRQ_RST_WORD      32'h0000_0000

// Encodings
`define EIRQ_MM_MAX        3'h5
`define EIRQ_INTA_CODE     8'h00
`define EIRQ_LVL_ASSERT    1'b0
`define EIRQ_LVL_DEASSERT  1'b1

`endif

// ---- eirq_pkg.sv ----
`include "eirq_regs.svh"

package eirq_pkg;

    typedef enum logic [1:0] {
        EIRQ_KIND_INTX = 2'h0,
        EIRQ_KIND_MSI  = 2'h1,
        EIRQ_KIND_MSIX = 2'h2
    } eirq_kind_t;

    typedef enum logic [1:0] {
        EIRQ_IDLE = 2'b01,
        EIRQ_SEND = 2'b10
    } eirq_state_t;

    typedef enum logic [1:0] {
        EIRQ_U_IDLE = 2'b01,
        EIRQ_U_WAIT = 2'b10
    } eirq_ustate_t;

    // Low-order message data bits that a vector may override
    function automatic logic [7:0] eirq_vec_mask(input logic [2:0] mm);
        logic [2:0] n;
        n = (mm > `EIRQ_MM_MAX) ? `EIRQ_MM_MAX : mm;
        return (8'h01 << n) - 8'h01;
    endfunction

endpackage

// ---- eirq_if.sv ----
`timescale 1ns/10ps

interface eirq_if;
    logic       irq_req;
    logic       irq_gnt;
    logic       lvl_deassert;
    logic [7:0] msi_vector_in;
    logic [4:0] msg_number;
    logic [7:0] msi_data_lo;
    logic [2:0] mm_enable;
    logic       msi_on;
    logic       msix_on;
    logic       msix_fmask;

    modport dev (
        input  irq_req,
        input  lvl_deassert,
        input  msi_vector_in,
        input  msg_number,
        output irq_gnt,
        output msi_data_lo,
        output mm_enable,
        output msi_on,
        output msix_on,
        output msix_fmask
    );

    modport usr (
        output irq_req,
        output lvl_deassert,
        output msi_vector_in,
        output msg_number,
        input  irq_gnt,
        input  msi_data_lo,
        input  mm_enable,
        input  msi_on,
        input  msix_on,
        input  msix_fmask
    );
endinterface

// ---- eirq_usr.sv ----
`timescale 1ns/10ps

`include "eirq_regs.svh"

module eirq_usr
    import eirq_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // Interrupt request port
    eirq_if.usr              lnk,
    // Wishbone slave
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Interrupt to software
    output logic             irq_o
);

    // ****************************************************************
    // Declarations
    // ****************************************************************

    eirq_ustate_t ust;
    logic         wr_ok;
    logic         start;
    logic [7:0]   vector;
    logic [4:0]   msgnum;
    logic [7:0]   vec_mask;
    logic [7:0]   fix_num;
    logic [1:0]   ev_stat;
    logic [1:0]   ev_mask;
    logic [1:0]   ev_set;
    logic [5:0]   cfg_prev;
    logic [5:0]   cfg_now;
    logic [31:0]  next_rd;

    // ****************************************************************
    // Wishbone slave
    // ****************************************************************

    // Writes land on the edge that samples ack
    assign wr_ok = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i &&
                   wb_sel_i[0];
    assign start = wr_ok && (wb_adr_i == `EIRQ_OFS_CTRL) &&
                   wb_dat_i[`EIRQ_CTRL_SEND] && (ust == EIRQ_U_IDLE);

    always_comb
    begin
        next_rd = `EIRQ_RST_WORD;
        if (wb_adr_i == `EIRQ_OFS_CTRL)
        begin
            next_rd[`EIRQ_CTRL_SEND]     = lnk.irq_req;
            next_rd[`EIRQ_CTRL_DEASSERT] = lnk.lvl_deassert;
        end
        else if (wb_adr_i == `EIRQ_OFS_VECTOR)
        begin
            next_rd[7:0] = vector;
        end
        else if (wb_adr_i == `EIRQ_OFS_MSGNUM)
        begin
            next_rd[4:0] = msgnum;
        end
        else if (wb_adr_i == `EIRQ_OFS_STATUS)
        begin
            next_rd[`EIRQ_ST_MM_LO+2:0] = cfg_now;
            next_rd[`EIRQ_ST_DATA_LO+7:`EIRQ_ST_DATA_LO] = lnk.msi_data_lo;
            next_rd[`EIRQ_ST_BUSY] = (ust == EIRQ_U_WAIT);
        end
        else if (wb_adr_i == `EIRQ_OFS_IRQ_STAT)
        begin
            next_rd[1:0] = ev_stat;
        end
        else if (wb_adr_i == `EIRQ_OFS_IRQ_MASK)
        begin
            next_rd[1:0] = ev_mask;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= `EIRQ_RST_WORD;
        end
        else
        begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (wb_cyc_i && wb_stb_i && !wb_ack_o)
            begin
                wb_dat_o <= next_rd;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            vector  <= `EIRQ_RST_BYTE;
            msgnum  <= `EIRQ_RST_MSGNUM;
            ev_mask <= `EIRQ_RST_EV;
        end
        else if (wr_ok)
        begin
            if (wb_adr_i == `EIRQ_OFS_VECTOR)
            begin
                vector <= wb_dat_i[7:0];
            end
            else if (wb_adr_i == `EIRQ_OFS_MSGNUM)
            begin
                msgnum <= wb_dat_i[4:0];
            end
            else if (wb_adr_i == `EIRQ_OFS_IRQ_MASK)
            begin
                ev_mask <= wb_dat_i[1:0];
            end
        end
    end

    // ****************************************************************
    // Request handshake
    // ****************************************************************

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ust              <= EIRQ_U_IDLE;
            lnk.irq_req      <= 1'b0;
            lnk.lvl_deassert <= `EIRQ_LVL_ASSERT;
        end
        else
        begin
            case (ust)
                EIRQ_U_IDLE:
                begin
                    if (start)
                    begin
                        ust              <= EIRQ_U_WAIT;
                        lnk.irq_req      <= 1'b1;
                        lnk.lvl_deassert <= wb_dat_i[`EIRQ_CTRL_DEASSERT];
                    end
                end
                EIRQ_U_WAIT:
                begin
                    if (lnk.irq_gnt)
                    begin
                        ust         <= EIRQ_U_IDLE;
                        lnk.irq_req <= 1'b0;
                    end
                end
                default:
                begin
                    ust         <= EIRQ_U_IDLE;
                    lnk.irq_req <= 1'b0;
                end
            endcase
        end
    end

    // ****************************************************************
    // Vector and message number
    // ****************************************************************

    assign vec_mask = eirq_vec_mask(lnk.mm_enable);
    assign fix_num = (lnk.msi_on && !lnk.msix_on &&
                      ({3'h0, msgnum} > vec_mask)) ? vec_mask
                                                   : {3'h0, msgnum};

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lnk.msi_vector_in <= `EIRQ_RST_BYTE;
            lnk.msg_number    <= `EIRQ_RST_MSGNUM;
        end
        else
        begin
            lnk.msi_vector_in <= lnk.msix_on ? vector : (vector & vec_mask);
            lnk.msg_number    <= fix_num[4:0];
        end
    end

    // ****************************************************************
    // Event status and interrupt
    // ****************************************************************

    assign cfg_now = {lnk.mm_enable, lnk.msix_fmask, lnk.msix_on,
                      lnk.msi_on};
    assign ev_set  = {cfg_now != cfg_prev,
                      lnk.irq_req && lnk.irq_gnt};

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cfg_prev <= 6'h00;
            ev_stat  <= `EIRQ_RST_EV;
        end
        else
        begin
            cfg_prev <= cfg_now;
            if (wr_ok && (wb_adr_i == `EIRQ_OFS_IRQ_STAT))
            begin
                ev_stat <= (ev_stat & ~wb_dat_i[1:0]) | ev_set;
            end
            else
            begin
                ev_stat <= ev_stat | ev_set;
            end
        end
    end

    assign irq_o = |(ev_stat & ev_mask);

endmodule

// ---- eirq_chk.sv ----
`timescale 1ns/10ps

module eirq_chk (
    // Clock and reset
    input wire logic       clk_sys,
    input wire logic       rst_b,
    // Request side
    input wire logic       irq_req,
    input wire logic       lvl_deassert,
    input wire logic [7:0] msi_vector_in,
    input wire logic [4:0] msg_number,
    // Device side
    input wire logic       irq_gnt,
    input wire logic [7:0] msi_data_lo,
    input wire logic [2:0] mm_enable,
    input wire logic       msi_on,
    input wire logic       msix_on,
    input wire logic       msix_fmask
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    // ****************************************
    // Vector bits allowed by the message count
    // ****************************************
    logic [7:0] vmask;
    assign vmask = (8'h01 << mm_enable) - 8'h01;

    gnt_with_req_a: assert property (irq_gnt |-> irq_req)
        else $error("grant without request");
    req_held_a: assert property (irq_req && !irq_gnt |=>
        irq_req && $stable(lvl_deassert) && $stable(msi_vector_in))
        else $error("request changed before grant");
    gnt_pulse_a: assert property (irq_gnt |=> !irq_gnt)
        else $error("grant longer than one cycle");
    req_drop_a: assert property (irq_gnt |=> !irq_req)
        else $error("request kept after grant");
    fmask_block_a: assert property (
        irq_req && msix_on && msix_fmask |-> !irq_gnt)
        else $error("grant while function mask set");
    mm_range_a: assert property (mm_enable <= 3'h5)
        else $error("message enable out of range");
    vec_width_a: assert property (
        irq_req && msi_on && !msix_on |-> (msi_vector_in & ~vmask) == 8'h00)
        else $error("vector bits above message count");
    msgnum_fit_a: assert property (
        (msi_on && !msix_on && $stable(mm_enable) && $stable(msg_number))[*2]
        |-> {3'h0, msg_number} <= vmask)
        else $error("message number beyond enabled vectors");

    cover property (irq_gnt && msi_on);
    cover property (irq_req && msix_on && msix_fmask);
    cover property (irq_gnt && !msi_on && !msix_on && lvl_deassert);
endmodule

// ---- testbench.sv ----
`timescale 1ns/10ps

`include "eirq_regs.svh"

module testbench
    import eirq_pkg::*;
;
    logic        clk_sys;
    logic        rst_b;
    logic        host_msi_en;
    logic        host_msix_en;
    logic        host_msix_fmask;
    logic [2:0]  host_mm_en;
    logic [15:0] host_msi_data;
    logic        tx_ready;
    logic        tx_valid;
    eirq_kind_t  tx_kind;
    logic [15:0] tx_data;
    logic [4:0]  cap_msgnum;
    logic        intx_asserted;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i;
    logic [3:0]  wb_sel_i;
    logic        wb_we_i;
    logic        wb_cyc_i;
    logic        wb_stb_i;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        irq_o;
    logic [31:0] rd;
    logic [7:0]  m;
    logic        got;
    int          bad_count;
    int          n_tests;
    int          k;
    int          j;

    eirq_if lnk_if ();

    eirq_dev u_eirq_dev (.clk_sys, .rst_b, .lnk(lnk_if), .host_msi_en,
        .host_msix_en, .host_msix_fmask, .host_mm_en, .host_msi_data,
        .tx_ready, .tx_valid, .tx_kind, .tx_data, .cap_msgnum,
        .intx_asserted);

    eirq_usr u_eirq_usr (.clk_sys, .rst_b, .lnk(lnk_if), .wb_adr_i,
        .wb_dat_i, .wb_sel_i, .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o,
        .wb_ack_o, .irq_o);

    eirq_chk u_eirq_chk (.clk_sys, .rst_b, .irq_req(lnk_if.irq_req),
        .lvl_deassert(lnk_if.lvl_deassert), .irq_gnt(lnk_if.irq_gnt),
        .msi_vector_in(lnk_if.msi_vector_in), .msi_on(lnk_if.msi_on),
        .msg_number(lnk_if.msg_number), .msix_on(lnk_if.msix_on),
        .msi_data_lo(lnk_if.msi_data_lo), .mm_enable(lnk_if.mm_enable),
        .msix_fmask(lnk_if.msix_fmask));

    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: saw %h, expected %h",
                $time, seen, exp);
        end
    endtask

    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] d);
        @(posedge clk_sys);
        wb_adr_i <= a;
        wb_we_i  <= w;
        wb_dat_i <= d;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        // Wait for ack; only the watchdog ends a hung access
        do
        begin
            @(negedge clk_sys);
        end
        while (wb_ack_o !== 1'b1);
        @(posedge clk_sys);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask

    task automatic wait_tx(input int lim);
        int n;
        n = 0;
        got = 1'b0;
        while (!got && n < lim)
        begin
            @(negedge clk_sys);
            n++;
            got = (tx_valid === 1'b1);
        end
    endtask

    task automatic host(input logic a, input logic b, input logic c,
                        input logic [2:0] mm);
        @(posedge clk_sys);
        host_msi_en     <= a;
        host_msix_en    <= b;
        host_msix_fmask <= c;
        host_mm_en      <= mm;
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic give_verdict;
        if (bad_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ****************************************
    // Clock, watchdog and test sequence
    // ****************************************
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        bad_count++;
        give_verdict();
    end

    initial
    begin
        rst_b = 1'b0;
        {host_msi_en, host_msix_en, host_msix_fmask} = 3'h0;
        host_mm_en = 3'h0;
        host_msi_data = 16'hab5c;
        tx_ready = 1'b1;
        {wb_adr_i, wb_dat_i, wb_we_i, wb_cyc_i, wb_stb_i} = '0;
        wb_sel_i = 4'hf;
        bad_count = 0;
        n_tests = 0;
        repeat (8) @(posedge clk_sys);
        rst_b <= 1'b1;
        xfer(`EIRQ_OFS_IRQ_MASK, 1'b0, 32'h0);
        chk(rd, `EIRQ_RST_WORD);
        xfer(8'h1c, 1'b1, 32'hffff_ffff);
        xfer(8'h1c, 1'b0, 32'h0);
        chk(rd, 32'h0);
        xfer(`EIRQ_OFS_STATUS, 1'b0, 32'h0);
        chk(rd, 32'h0000_5c00);
        xfer(`EIRQ_OFS_IRQ_MASK, 1'b1, 32'h1);
        tx_ready <= 1'b0;
        xfer(`EIRQ_OFS_CTRL, 1'b1, 32'h1);
        wait_tx(10);
        chk(got, 1'b0);
        xfer(`EIRQ_OFS_STATUS, 1'b0, 32'h0);
        chk(rd[16], 1'b1);
        tx_ready <= 1'b1;
        for (k = 0; k < 2; k++)
        begin
            if (k == 1)
                xfer(`EIRQ_OFS_CTRL, 1'b1, 32'h3);
            wait_tx(20);
            chk(got, 1'b1);
            chk(tx_kind, EIRQ_KIND_INTX);
            chk(tx_data, {7'h0, k[0], 8'h00});
            @(negedge clk_sys);
            chk(intx_asserted, k == 0);
        end
        chk(irq_o, 1'b1);
        xfer(`EIRQ_OFS_IRQ_STAT, 1'b1, 32'h1);
        @(negedge clk_sys);
        chk(irq_o, 1'b0);
        xfer(`EIRQ_OFS_VECTOR, 1'b1, 32'ha3);
        xfer(`EIRQ_OFS_MSGNUM, 1'b1, 32'h1f);
        repeat (3) @(negedge clk_sys);
        chk(cap_msgnum, 5'h1f);
        for (k = 0; k < 8; k++)
        begin
            host(1'b1, 1'b0, 1'b0, k[2:0]);
            j = (k > 5) ? 5 : k;
            m = (8'h01 << j) - 8'h01;
            xfer(`EIRQ_OFS_STATUS, 1'b0, 32'h0);
            chk(rd, {16'h0, 8'h5c, 2'h0, j[2:0], 3'h1});
            chk(cap_msgnum, m[4:0]);
            xfer(`EIRQ_OFS_CTRL, 1'b1, 32'h1);
            wait_tx(20);
            chk(got, 1'b1);
            chk(tx_kind, EIRQ_KIND_MSI);
            chk(tx_data, {8'hab, (8'h5c & ~m) | (8'ha3 & m)});
        end
        xfer(`EIRQ_OFS_IRQ_STAT, 1'b0, 32'h0);
        chk(rd[1], 1'b1);
        host(1'b0, 1'b1, 1'b1, 3'h0);
        xfer(`EIRQ_OFS_STATUS, 1'b0, 32'h0);
        chk(rd[2:0], 3'h6);
        xfer(`EIRQ_OFS_CTRL, 1'b1, 32'h1);
        wait_tx(20);
        chk(got, 1'b0);
        @(posedge clk_sys);
        host_msix_fmask <= 1'b0;
        wait_tx(20);
        chk(got, 1'b1);
        chk(tx_kind, EIRQ_KIND_MSIX);
        chk(tx_data, 16'h00a3);
        give_verdict();
    end
endmodule
